// ==== verilog/mac_frame_defines.svh ====
/*
 Register map, field positions, reset values and codes of the MAC frame engine.
 Assumes inclusion by bare name from the engine file.
*/
`ifndef MAC_FRAME_DEFINES_SVH
`define MAC_FRAME_DEFINES_SVH
`define A_CTRL 12'h000
`define A_STAT 12'h004
`define A_FLAG 12'h008
`define A_PIN 12'h00C
`define A_IEN 12'h010
`define A_NODE 12'h014
`define A_ACKTO 12'h018
`define A_GPIO 12'h01C
`define A_TXB 12'h800
`define A_RXB 12'hA00
`define BUF_MASK 12'hE00
`define CTRL_RST 8'h22
`define PIN_RST 8'h40
`define PIN_EN_BIT 6
`define PIN_PEND_BIT 4
`define ACKTO_RST 16'h1000
`define MAXRE_RST 4'h3
`define F_RX 0
`define F_TX 1
`define F_REJ 2
`define F_FAIL 3
`define GM_NORMAL 4'h0
`define GM_TIMING 4'h5
`define GM_TXSTR 4'hA
`define GM_RXSTR 4'hB
`define FC_ACKREQ 5
`define FC_ACK 8'h02
`define ACK_LEN 8'h05
`define ACK_LAST 7'h05
`define FCS_LEN 8'h02
`define LEN_MAX 8'h7D
`define LEN_MASK 8'h7F
`define CRC_POLY 16'h8408
`define CRC_INIT 16'h0000
`define BCAST 16'hFFFF
`endif

// ==== verilog/mac_frame_pkg.sv ====
/*
 Types of the MAC frame engine: sequencer states and control fields.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package mac_frame_pkg;
	typedef enum logic [3:0] {S_IDLE, S_RXLEN, S_RXDATA, S_RXSTAT, S_RXCHK, S_RXDROP, S_ACKSHR, S_ACKDATA,
		S_RXFIN, S_TXPARSE, S_TXFCS, S_TXAPP, S_TXCCA, S_TXSHR, S_TXDATA, S_TXWAIT} state_e;
	typedef struct packed {
		logic rx_en;
		logic prop;
		logic filt;
		logic rej_irq;
		logic retx;
		logic bypass;
		logic auto_ack;
		logic go;
	} ctrl_s;
endpackage
`default_nettype wire

// ==== verilog/mac_frame_tx_rx_engine.sv ====
/*
 MAC frame engine: receive and transmit buffers, frame sequencer, flags, interrupt pin and pin functions.
 Assumes a Wishbone classic master and a modem on the same clock with byte handshakes.
*/
`include "mac_frame_defines.svh"
`default_nettype none
module mac_frame_tx_rx_engine (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_rx_sync,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic [7:0] i_rx_status,
	output logic o_cca_req,
	input wire logic i_cca_done,
	input wire logic i_cca_free,
	output logic o_tx_shr,
	input wire logic i_tx_shr_done,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	output logic o_rx_on,
	output logic o_tx_on,
	output logic o_irq_b,
	output logic [2:0] o_gpio,
	output logic [2:0] o_gpio_oe
);
	mac_frame_pkg::state_e st_ff;
	mac_frame_pkg::ctrl_s ctrl_ff;
	logic [7:0] tx_buf [0:127];
	logic [7:0] rx_buf [0:127];
	logic [7:0] flag_ff, ien_ff, gpio_ff;
	logic [15:0] node_ff, ackto_ff, crc_ff, tmr_ff, ack_crc_ff;
	logic [3:0] maxre_ff, retry_ff, gmode_ff, ev_ff;
	logic pin_en_ff, rx_full_ff, tx_empty_ff, tx_go_ff, set_full_ff;
	logic [6:0] idx_ff, nidx;
	logic [7:0] len_ff, seq_ff, last_seq_ff, nbyte, rd_val;
	logic ackreq_ff, dup_ff, last_ok_ff, typ_ok_ff;
	logic req, wr, rd, hit_tx, hit_rx, take, tx_take, pending;
	logic rx_we, tx_we;
	logic [6:0] rx_wa, tx_wa;
	logic [7:0] rx_wd, tx_wd;
	logic [15:0] dest;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic buf_hit(input logic [11:0] a, input logic [11:0] base);
		return (a & `BUF_MASK) == base;
	endfunction

	function automatic logic is_tx(input mac_frame_pkg::state_e s);
		return s inside {mac_frame_pkg::S_ACKSHR, mac_frame_pkg::S_ACKDATA, mac_frame_pkg::S_TXPARSE,
			mac_frame_pkg::S_TXFCS, mac_frame_pkg::S_TXAPP, mac_frame_pkg::S_TXCCA,
			mac_frame_pkg::S_TXSHR, mac_frame_pkg::S_TXDATA};
	endfunction

	assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wr = req & i_wb_we & i_wb_sel[0];
	assign rd = req & ~i_wb_we;
	assign hit_tx = buf_hit(i_wb_adr, `A_TXB);
	assign hit_rx = buf_hit(i_wb_adr, `A_RXB);
	assign take = o_tx_valid & i_tx_ready;
	assign tx_take = (st_ff == mac_frame_pkg::S_IDLE) & tx_go_ff;
	assign pending = |(flag_ff & ien_ff);
	assign dest = {rx_buf[5], rx_buf[4]};

	// Register read mux
	always_comb begin
		rd_val = 8'h00;
		if (i_wb_adr == `A_CTRL) begin
			rd_val = {ctrl_ff[7:1], 1'b0};
		end else if (i_wb_adr == `A_STAT) begin
			rd_val = {5'h00, st_ff != mac_frame_pkg::S_IDLE, tx_empty_ff, rx_full_ff};
		end else if (i_wb_adr == `A_FLAG) begin
			rd_val = flag_ff;
		end else if (i_wb_adr == `A_PIN) begin
			rd_val = {1'b0, pin_en_ff, 1'b0, pending, gmode_ff};
		end else if (i_wb_adr == `A_IEN) begin
			rd_val = ien_ff;
		end else if (i_wb_adr == `A_GPIO) begin
			rd_val = gpio_ff;
		end else if (hit_tx) begin
			rd_val = tx_buf[i_wb_adr[8:2]];
		end else if (hit_rx && rx_full_ff) begin
			rd_val = rx_buf[i_wb_adr[8:2]];
		end
	end

	// Bus answer, one cycle after the request
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else if (i_ce) begin
			o_wb_ack <= req;
			if (rd) begin
				if (i_wb_adr == `A_NODE) begin
					o_wb_dat <= {16'h0000, node_ff};
				end else if (i_wb_adr == `A_ACKTO) begin
					o_wb_dat <= {12'h000, maxre_ff, ackto_ff};
				end else begin
					o_wb_dat <= {24'h00_0000, rd_val};
				end
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_ff <= `CTRL_RST;
			ien_ff <= 8'h00;
			gpio_ff <= 8'h00;
			pin_en_ff <= 1'(`PIN_RST >> `PIN_EN_BIT);
			gmode_ff <= `GM_NORMAL;
			node_ff <= 16'h0000;
			ackto_ff <= `ACKTO_RST;
			maxre_ff <= `MAXRE_RST;
		end else if (i_ce && req && i_wb_we) begin
			if (i_wb_sel[0]) begin
				if (i_wb_adr == `A_CTRL) begin
					ctrl_ff <= {i_wb_dat[7:1], 1'b0};
				end else if (i_wb_adr == `A_IEN) begin
					ien_ff <= i_wb_dat[7:0];
				end else if (i_wb_adr == `A_GPIO) begin
					gpio_ff <= i_wb_dat[7:0];
				end else if (i_wb_adr == `A_PIN) begin
					pin_en_ff <= i_wb_dat[`PIN_EN_BIT];
					gmode_ff <= i_wb_dat[3:0];
				end else if (i_wb_adr == `A_NODE) begin
					node_ff[7:0] <= i_wb_dat[7:0];
				end else if (i_wb_adr == `A_ACKTO) begin
					ackto_ff[7:0] <= i_wb_dat[7:0];
				end
			end
			if (i_wb_sel[1] && i_wb_adr == `A_NODE) begin
				node_ff[15:8] <= i_wb_dat[15:8];
			end
			if (i_wb_sel[1] && i_wb_adr == `A_ACKTO) begin
				ackto_ff[15:8] <= i_wb_dat[15:8];
			end
			if (i_wb_sel[2] && i_wb_adr == `A_ACKTO) begin
				maxre_ff <= i_wb_dat[19:16];
			end
		end
	end

	// Transmit trigger, set wins over take
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_go_ff <= 1'b0;
		end else if (i_ce) begin
			tx_go_ff <= (tx_go_ff & ~tx_take) | (wr & (i_wb_adr == `A_CTRL) & i_wb_dat[0]);
		end
	end

	// Interrupt flags: clear on read, host may set, hardware set wins
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flag_ff <= 8'h00;
		end else if (i_ce) begin
			flag_ff <= (flag_ff & ~{8{rd && i_wb_adr == `A_FLAG}})
				| ((wr && i_wb_adr == `A_FLAG) ? i_wb_dat[7:0] : 8'h00)
				| {4'h0, ev_ff};
		end
	end

	// Receive lock and transmit empty status
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_full_ff <= 1'b0;
			tx_empty_ff <= 1'b1;
		end else if (i_ce) begin
			if (set_full_ff) begin
				rx_full_ff <= 1'b1;
			end else if (wr && i_wb_adr == `A_STAT && !i_wb_dat[0]) begin
				rx_full_ff <= 1'b0;
			end
			if (ev_ff[`F_TX]) begin
				tx_empty_ff <= 1'b1;
			end else if (wr && hit_tx) begin
				tx_empty_ff <= 1'b0;
			end
		end
	end

	// Engine writes into the buffers
	always_comb begin
		rx_we = 1'b0;
		rx_wa = idx_ff;
		rx_wd = i_rx_data;
		tx_we = 1'b0;
		tx_wa = 7'h00;
		tx_wd = 8'h00;
		case (st_ff)
			mac_frame_pkg::S_RXLEN: rx_we = i_rx_valid;
			mac_frame_pkg::S_RXDATA: rx_we = i_rx_valid;
			mac_frame_pkg::S_RXSTAT: begin
				rx_we = len_ff != `LEN_MASK;
				rx_wd = i_rx_status;
			end
			mac_frame_pkg::S_TXAPP: begin
				tx_we = 1'b1;
				tx_wa = (idx_ff == 7'h00) ? 7'(len_ff + 8'h01) : (idx_ff == 7'h01) ? 7'(len_ff + 8'h02) : 7'h00;
				tx_wd = (idx_ff == 7'h00) ? crc_ff[7:0] : (idx_ff == 7'h01) ? crc_ff[15:8] : 8'(len_ff + `FCS_LEN);
			end
			default: ;
		endcase
	end

	// Buffer storage
	always_ff @(posedge i_clk_sys) begin
		if (i_ce) begin
			if (rx_we) begin
				rx_buf[rx_wa] <= rx_wd;
			end else if (wr && hit_rx && rx_full_ff) begin
				rx_buf[i_wb_adr[8:2]] <= i_wb_dat[7:0];
			end
			if (tx_we) begin
				tx_buf[tx_wa] <= tx_wd;
			end else if (wr && hit_tx) begin
				tx_buf[i_wb_adr[8:2]] <= i_wb_dat[7:0];
			end
		end
	end

	// Next byte to the modulator
	always_comb begin
		nidx = idx_ff + (take ? 7'h01 : 7'h00);
		nbyte = tx_buf[nidx];
		if (st_ff == mac_frame_pkg::S_ACKSHR || st_ff == mac_frame_pkg::S_ACKDATA) begin
			case (nidx[2:0])
				3'h0: nbyte = `ACK_LEN;
				3'h1: nbyte = `FC_ACK;
				3'h2: nbyte = 8'h00;
				3'h3: nbyte = seq_ff;
				3'h4: nbyte = ack_crc_ff[7:0];
				default: nbyte = ack_crc_ff[15:8];
			endcase
		end
	end

	// Frame sequencer; one state machine keeps the two paths exclusive
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_ff <= mac_frame_pkg::S_IDLE;
			idx_ff <= 7'h00;
			len_ff <= 8'h00;
			crc_ff <= `CRC_INIT;
			ack_crc_ff <= `CRC_INIT;
			tmr_ff <= 16'h0000;
			retry_ff <= 4'h0;
			seq_ff <= 8'h00;
			last_seq_ff <= 8'h00;
			last_ok_ff <= 1'b0;
			ackreq_ff <= 1'b0;
			dup_ff <= 1'b0;
			typ_ok_ff <= 1'b0;
			ev_ff <= 4'h0;
			set_full_ff <= 1'b0;
			o_cca_req <= 1'b0;
			o_tx_shr <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
		end else if (i_ce) begin
			ev_ff <= 4'h0;
			set_full_ff <= 1'b0;
			case (st_ff)
				mac_frame_pkg::S_IDLE: begin
					idx_ff <= 7'h00;
					if (tx_go_ff) begin
						st_ff <= mac_frame_pkg::S_TXPARSE;
					end else if (i_rx_sync && ctrl_ff.rx_en) begin
						st_ff <= rx_full_ff ? mac_frame_pkg::S_RXDROP : mac_frame_pkg::S_RXLEN;
					end
				end
				mac_frame_pkg::S_RXDROP: begin
					if (i_rx_valid) begin
						if (idx_ff == 7'h00) begin
							len_ff <= i_rx_data & `LEN_MASK;
							idx_ff <= 7'h01;
							if ((i_rx_data & `LEN_MASK) == 8'h00) begin
								st_ff <= mac_frame_pkg::S_IDLE;
							end
						end else begin
							idx_ff <= idx_ff + 7'h01;
							if ({1'b0, idx_ff} >= len_ff) begin
								st_ff <= mac_frame_pkg::S_IDLE;
							end
						end
					end
				end
				mac_frame_pkg::S_RXLEN: begin
					if (i_rx_valid) begin
						len_ff <= i_rx_data & `LEN_MASK;
						idx_ff <= 7'h01;
						crc_ff <= `CRC_INIT;
						st_ff <= ((i_rx_data & `LEN_MASK) == 8'h00) ? mac_frame_pkg::S_RXSTAT : mac_frame_pkg::S_RXDATA;
					end
				end
				mac_frame_pkg::S_RXDATA: begin
					if (i_rx_valid) begin
						crc_ff <= crc_upd(crc_ff, i_rx_data);
						idx_ff <= idx_ff + 7'h01;
						if ({1'b0, idx_ff} == len_ff) begin
							st_ff <= mac_frame_pkg::S_RXSTAT;
						end
					end
				end
				mac_frame_pkg::S_RXSTAT: st_ff <= mac_frame_pkg::S_RXCHK;
				mac_frame_pkg::S_RXCHK: begin
					if (crc_ff != `CRC_INIT || (ctrl_ff.filt && !ctrl_ff.prop && dest != node_ff && dest != `BCAST)) begin
						ev_ff[`F_REJ] <= ctrl_ff.rej_irq;
						st_ff <= mac_frame_pkg::S_IDLE;
					end else begin
						seq_ff <= rx_buf[3];
						dup_ff <= last_ok_ff && (last_seq_ff == rx_buf[3]);
						last_seq_ff <= rx_buf[3];
						last_ok_ff <= 1'b1;
						ack_crc_ff <= crc_upd(crc_upd(crc_upd(`CRC_INIT, `FC_ACK), 8'h00), rx_buf[3]);
						idx_ff <= 7'h00;
						if (rx_buf[1][`FC_ACKREQ] && ctrl_ff.auto_ack) begin
							st_ff <= mac_frame_pkg::S_ACKSHR;
						end else begin
							st_ff <= mac_frame_pkg::S_RXFIN;
						end
					end
				end
				mac_frame_pkg::S_ACKSHR, mac_frame_pkg::S_TXSHR: begin
					if (!o_tx_shr) begin
						o_tx_shr <= 1'b1;
					end else if (i_tx_shr_done) begin
						o_tx_shr <= 1'b0;
						o_tx_valid <= 1'b1;
						o_tx_data <= nbyte;
						st_ff <= (st_ff == mac_frame_pkg::S_ACKSHR) ? mac_frame_pkg::S_ACKDATA : mac_frame_pkg::S_TXDATA;
					end
				end
				mac_frame_pkg::S_ACKDATA: begin
					if (take) begin
						idx_ff <= nidx;
						o_tx_data <= nbyte;
						if (idx_ff == `ACK_LAST) begin
							o_tx_valid <= 1'b0;
							st_ff <= mac_frame_pkg::S_RXFIN;
						end
					end
				end
				mac_frame_pkg::S_RXFIN: begin
					set_full_ff <= !dup_ff;
					st_ff <= mac_frame_pkg::S_IDLE;
				end
				mac_frame_pkg::S_TXPARSE: begin
					len_ff <= tx_buf[0];
					ackreq_ff <= tx_buf[1][`FC_ACKREQ];
					seq_ff <= tx_buf[3];
					retry_ff <= 4'h0;
					idx_ff <= 7'h01;
					crc_ff <= `CRC_INIT;
					if (tx_buf[0] > `LEN_MAX) begin
						ev_ff[`F_FAIL] <= 1'b1;
						st_ff <= mac_frame_pkg::S_IDLE;
					end else begin
						st_ff <= mac_frame_pkg::S_TXFCS;
					end
				end
				mac_frame_pkg::S_TXFCS: begin
					if ({1'b0, idx_ff} > len_ff) begin
						idx_ff <= 7'h00;
						st_ff <= mac_frame_pkg::S_TXAPP;
					end else begin
						crc_ff <= crc_upd(crc_ff, tx_buf[idx_ff]);
						idx_ff <= idx_ff + 7'h01;
					end
				end
				mac_frame_pkg::S_TXAPP: begin
					idx_ff <= idx_ff + 7'h01;
					if (idx_ff == 7'h02) begin
						len_ff <= len_ff + `FCS_LEN;
						st_ff <= mac_frame_pkg::S_TXCCA;
					end
				end
				mac_frame_pkg::S_TXCCA: begin
					idx_ff <= 7'h00;
					if (ctrl_ff.bypass) begin
						st_ff <= mac_frame_pkg::S_TXSHR;
					end else if (!o_cca_req) begin
						o_cca_req <= 1'b1;
					end else if (i_cca_done) begin
						o_cca_req <= 1'b0;
						if (i_cca_free) begin
							st_ff <= mac_frame_pkg::S_TXSHR;
						end else begin
							ev_ff[`F_FAIL] <= 1'b1;
							st_ff <= mac_frame_pkg::S_IDLE;
						end
					end
				end
				mac_frame_pkg::S_TXDATA: begin
					if (take) begin
						idx_ff <= nidx;
						o_tx_data <= nbyte;
						if ({1'b0, idx_ff} == len_ff) begin
							o_tx_valid <= 1'b0;
							idx_ff <= 7'h00;
							tmr_ff <= 16'h0000;
							typ_ok_ff <= 1'b0;
							if (ackreq_ff) begin
								st_ff <= mac_frame_pkg::S_TXWAIT;
							end else begin
								ev_ff[`F_TX] <= 1'b1;
								st_ff <= mac_frame_pkg::S_IDLE;
							end
						end
					end
				end
				mac_frame_pkg::S_TXWAIT: begin
					tmr_ff <= tmr_ff + 16'h0001;
					if (i_rx_sync) begin
						idx_ff <= 7'h00;
					end else if (i_rx_valid) begin
						idx_ff <= idx_ff + 7'h01;
						if (idx_ff == 7'h01) begin
							typ_ok_ff <= i_rx_data[2:0] == `FC_ACK;
						end
					end
					if (i_rx_valid && !i_rx_sync && idx_ff == 7'h03 && typ_ok_ff && i_rx_data == seq_ff) begin
						ev_ff[`F_TX] <= 1'b1;
						st_ff <= mac_frame_pkg::S_IDLE;
					end else if (tmr_ff >= ackto_ff) begin
						if (ctrl_ff.retx && retry_ff < maxre_ff) begin
							retry_ff <= retry_ff + 4'h1;
							st_ff <= mac_frame_pkg::S_TXCCA;
						end else begin
							ev_ff[`F_FAIL] <= 1'b1;
							st_ff <= mac_frame_pkg::S_IDLE;
						end
					end
				end
				default: st_ff <= mac_frame_pkg::S_IDLE;
			endcase
			if (set_full_ff) begin
				ev_ff[`F_RX] <= 1'b1;
			end
		end
	end

	// Path indications, interrupt pin and pin functions
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx_on <= 1'b0;
			o_tx_on <= 1'b0;
			o_irq_b <= 1'b1;
			o_gpio <= 3'h0;
			o_gpio_oe <= 3'h0;
		end else if (i_ce) begin
			o_tx_on <= is_tx(st_ff);
			o_rx_on <= !is_tx(st_ff) && st_ff != mac_frame_pkg::S_IDLE;
			o_irq_b <= !(pin_en_ff && pending);
			o_gpio_oe <= 3'h7;
			case (gmode_ff)
				`GM_NORMAL: begin
					o_gpio <= gpio_ff[2:0];
					o_gpio_oe <= ~gpio_ff[6:4];
				end
				`GM_TIMING: begin
					o_gpio <= {gpio_ff[2], st_ff == mac_frame_pkg::S_IDLE && i_rx_sync && ctrl_ff.rx_en,
						o_tx_shr && i_tx_shr_done};
					o_gpio_oe <= {~gpio_ff[6], 2'h3};
				end
				`GM_RXSTR: o_gpio <= {rx_we, rd && hit_rx, rx_full_ff};
				`GM_TXSTR: o_gpio <= {take, wr && hit_tx, tx_empty_ff};
				4'h1, 4'h2, 4'h3, 4'h4: o_gpio <= st_ff[2:0];
				default: begin
					o_gpio <= 3'h0;
					o_gpio_oe <= 3'h0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== tb/mac_frame_chk.sv ====
/*
 Port checker of the MAC frame engine: bus handshake, modem handshakes, path exclusion, interrupt pin.
 Assumes it is bound to the engine top and sees nothing but its ports.
*/
`include "mac_frame_defines.svh"
`default_nettype none
module mac_frame_chk (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_cca_req,
	input wire logic i_cca_done,
	input wire logic i_cca_free,
	input wire logic o_tx_shr,
	input wire logic i_tx_shr_done,
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	input wire logic o_rx_on,
	input wire logic o_tx_on,
	input wire logic o_irq_b
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	property p_ack_next;
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("bus ack late");
	property p_ack_pulse;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");
	property p_excl;
		!(o_rx_on && o_tx_on);
	endproperty
	a_excl: assert property (p_excl) else $error("both paths active");
	property p_cca_hold;
		o_cca_req && !i_cca_done |=> o_cca_req;
	endproperty
	a_cca_hold: assert property (p_cca_hold) else $error("channel request dropped");
	property p_busy_no_shr;
		o_cca_req && i_cca_done && !i_cca_free |=> !o_tx_shr [*4];
	endproperty
	a_busy_no_shr: assert property (p_busy_no_shr) else $error("header on busy channel");
	property p_shr_hold;
		o_tx_shr && !i_tx_shr_done |=> o_tx_shr;
	endproperty
	a_shr_hold: assert property (p_shr_hold) else $error("header request dropped");
	property p_byte_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
	endproperty
	a_byte_hold: assert property (p_byte_hold) else $error("byte not held");
	property p_byte_order;
		o_tx_valid |-> o_tx_on && !o_tx_shr && !o_cca_req;
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("byte out of order");
	property p_irq_off;
		o_wb_ack && i_wb_we && i_wb_adr == `A_PIN && !i_wb_dat[6] |-> ##[1:2] o_irq_b;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq pin not released");
	c_byte: cover property (o_tx_valid && i_tx_ready);
	c_busy: cover property (i_cca_done && !i_cca_free);
	c_irq: cover property ($fell(o_irq_b));
endmodule
bind mac_frame_tx_rx_engine mac_frame_chk i_chk (.i_clk_sys, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we,
	.i_wb_adr, .i_wb_dat, .o_wb_ack, .o_cca_req, .i_cca_done, .i_cca_free, .o_tx_shr, .i_tx_shr_done,
	.o_tx_valid, .o_tx_data, .i_tx_ready, .o_rx_on, .o_tx_on, .o_irq_b);
`default_nettype wire

// ==== tb/modem_model.sv ====
/*
 Modem model: answers channel checks, header requests and byte handshakes with random delays.
 Assumes the engine's registered request levels on the shared clock.
*/
`default_nettype none
module modem_model (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_busy,
	input wire logic i_cca_req,
	input wire logic i_tx_shr,
	output logic o_cca_done,
	output logic o_cca_free,
	output logic o_shr_done,
	output logic o_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic nd;
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cca_done <= 1'h0;
			o_cca_free <= 1'h0;
			o_shr_done <= 1'h0;
			o_tx_ready <= 1'h0;
		end else begin
			nd = i_cca_req && !o_cca_done && $urandom % 3 == 0;
			o_cca_done <= nd;
			o_cca_free <= nd ? !i_busy : ~o_cca_free;
			o_shr_done <= i_tx_shr && !o_shr_done && $urandom % 4 == 0;
			o_tx_ready <= 1'($urandom);
		end
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 Self-checking bench of the MAC frame engine: registers, receive, ack, transmit, pins.
 Assumes the engine, its defines header and the modem model.
*/
`include "mac_frame_defines.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, cyc, stb, we, ack, rsync, rval, txv, txr, rx_on, tx_on, irq_b, busy;
	logic cca_req, cca_done, cca_free, shr, shr_done;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [7:0] rdata, rstat, txd, seq, old;
	logic [2:0] gpio, oe;
	logic [7:0] fr[$], ex[$], txq[$];
	int errors, num_checks, cycles, ncca, nrx;
	mac_frame_tx_rx_engine i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(1'h1), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_rx_sync(rsync), .i_rx_valid(rval), .i_rx_data(rdata), .i_rx_status(rstat), .o_cca_req(cca_req),
		.i_cca_done(cca_done), .i_cca_free(cca_free), .o_tx_shr(shr), .i_tx_shr_done(shr_done),
		.o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr), .o_rx_on(rx_on), .o_tx_on(tx_on),
		.o_irq_b(irq_b), .o_gpio(gpio), .o_gpio_oe(oe));
	modem_model i_modem (.i_clk_sys(clk), .i_rst_b(rst_b), .i_busy(busy), .i_cca_req(cca_req),
		.i_tx_shr(shr), .o_cca_done(cca_done), .o_cca_free(cca_free), .o_shr_done(shr_done), .o_tx_ready(txr));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (txv && txr)
			txq.push_back(txd);
		if (cca_req && cca_done)
			ncca++;
		if (rx_on)
			nrx++;
		if (cycles == 40000) begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		wb(1'h0, a, 32'h0);
		chk(q[7:0] & m, e);
	endtask
	task automatic wirq(input int lim);
		for (int n = 0; n < lim && irq_b !== 1'h0; n++)
			@(posedge clk);
	endtask
	task automatic mk(input logic [7:0] fc, input int pl);
		seq = 8'($urandom);
		fr = '{fc, 8'h00, seq, 8'h34, 8'h12};
		repeat (pl) fr.push_back(8'($urandom));
	endtask
	task automatic bld(input logic [15:0] flip);
		logic [15:0] c;
		c = `CRC_INIT;
		foreach (fr[i])
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ fr[i][k]) ? (c >> 1) ^ `CRC_POLY : c >> 1;
		ex = fr;
		ex.push_front(8'(fr.size() + 2));
		ex.push_back(c[7:0] ^ flip[7:0]);
		ex.push_back(c[15:8]);
	endtask
	task automatic send(input logic [7:0] b);
		rval <= 1'h1;
		rdata <= b;
		@(posedge clk);
		rval <= 1'h0;
		rdata <= ~b;
		@(posedge clk);
	endtask
	task automatic rxf(input logic [15:0] flip);
		logic [7:0] st;
		st = 8'($urandom);
		bld(flip);
		rstat <= st;
		rsync <= 1'h1;
		@(posedge clk);
		rsync <= 1'h0;
		foreach (ex[i]) send(ex[i]);
		ex.push_back(st);
		wirq(200);
	endtask
	task automatic txf(input logic [7:0] cv, input int lim);
		foreach (ex[i]) wb(1'h1, 12'(`A_TXB + 4 * i), {24'h0, ex[i]});
		txq.delete();
		ncca = 0;
		nrx = 0;
		wb(1'h1, `A_CTRL, {24'h0, cv});
		wirq(lim);
	endtask
	initial begin
		void'($urandom(32'h8F3141D2));
		{rst_b, cyc, stb, we, rsync, rval, busy} = 7'h0;
		{adr, wdat, rdata, rstat} = 60'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		rd(`A_PIN, 8'hFF, 8'h40);
		rd(`A_CTRL, 8'hFF, 8'h22);
		rd(12'h020, 8'hFF, 8'h00);
		chk(oe, 3'h7);
		chk(irq_b, 1'h1);
		wb(1'h1, `A_IEN, 32'h0F);
		wb(1'h1, `A_NODE, 32'h1234);
		wb(1'h1, `A_ACKTO, 32'h30040);
		wb(1'h1, `A_CTRL, 32'hBA);
		mk(8'h01, 1 + int'($urandom % 20));
		rxf(16'h0);
		chk(irq_b, 1'h0);
		rd(`A_PIN, 8'h10, 8'h10);
		rd(`A_STAT, 8'h01, 8'h01);
		foreach (ex[i]) rd(12'(`A_RXB + 4 * i), 8'hFF, ex[i]);
		rd(`A_FLAG, 8'h01, 8'h01);
		rd(`A_FLAG, 8'hFF, 8'h00);
		old = ex[6];
		fr[5] = ~fr[5];
		rxf(16'h0);
		rd(12'(`A_RXB + 24), 8'hFF, old);
		rd(`A_FLAG, 8'h01, 8'h00);
		wb(1'h1, `A_STAT, 32'h0);
		rd(`A_STAT, 8'h01, 8'h00);
		rd(`A_RXB, 8'hFF, 8'h00);
		rxf(16'h1);
		rd(`A_FLAG, 8'h05, 8'h04);
		rd(`A_STAT, 8'h01, 8'h00);
		fr[4] = 8'h56;
		rxf(16'h0);
		rd(`A_FLAG, 8'h05, 8'h04);
		rd(`A_STAT, 8'h01, 8'h00);
		$display("test receive done");
		mk(8'h21, 4);
		for (int k = 0; k < 2; k++) begin
			txq.delete();
			rxf(16'h0);
			chk(txq[txq.size() - 3], seq);
			rd(`A_FLAG, 8'h01, 8'(k == 0));
			rd(`A_STAT, 8'h01, 8'(k == 0));
			wb(1'h1, `A_STAT, 32'h0);
		end
		wb(1'h1, `A_CTRL, 32'hB8);
		mk(8'h21, 4);
		txq.delete();
		rxf(16'h0);
		chk(txq.size(), 0);
		rd(`A_FLAG, 8'h01, 8'h01);
		$display("test ack done");
		busy <= 1'h1;
		mk(8'h01, 6);
		bld(16'h0);
		txf(8'hBB, 3000);
		rd(`A_FLAG, 8'h0A, 8'h08);
		chk(txq.size(), 0);
		busy <= 1'h0;
		mk(8'h21, 6);
		bld(16'h0);
		txf(8'hBB, 3000);
		rd(`A_FLAG, 8'h0A, 8'h08);
		chk(ncca, 4);
		chk(nrx >= 256 && nrx <= 264, 1'h1);
		mk(8'h21, 2);
		ex = fr;
		ex.push_front(8'(fr.size()));
		txf(8'hBB, 0);
		for (int n = 0; n < 3000 && rx_on !== 1'h1; n++)
			@(posedge clk);
		fr = '{8'h02, 8'h00, seq};
		bld(16'h0);
		rsync <= 1'h1;
		@(posedge clk);
		rsync <= 1'h0;
		foreach (ex[i]) send(ex[i]);
		wirq(200);
		rd(`A_FLAG, 8'h0A, 8'h02);
		chk(ncca, 1);
		mk(8'h01, int'($urandom % 119));
		ex = fr;
		ex.push_front(8'(fr.size()));
		txf(8'hBF, 3000);
		rd(`A_FLAG, 8'h0A, 8'h02);
		chk(ncca, 0);
		chk(nrx, 0);
		bld(16'h0);
		rd(`A_TXB, 8'hFF, ex[0]);
		chk(txq.size(), ex.size());
		for (int i = 0; i < ex.size(); i++)
			chk(txq[txq.size() - ex.size() + i], ex[i]);
		$display("test transmit done");
		for (int c = 0; c < 16; c++) begin
			wb(1'h1, `A_PIN, 32'(c) | 32'h40);
			rd(`A_PIN, 8'h4F, 8'(c) | 8'h40);
			chk(oe, (c < 6 || c == 10 || c == 11) ? 3'h7 : 3'h0);
			if (c == 0 || c == 5 || c == 10 || c == 11)
				chk(gpio, {2'h0, c > 9});
		end
		$display("test pins done");
		wb(1'h1, `A_FLAG, 32'h1);
		@(posedge clk);
		chk(irq_b, 1'h0);
		wb(1'h1, `A_PIN, 32'h0);
		@(posedge clk);
		chk(irq_b, 1'h1);
		rd(`A_PIN, 8'h50, 8'h10);
		rd(`A_FLAG, 8'hFF, 8'h01);
		$display("test irq done");
		complete_run();
	end
endmodule
`default_nettype wire
